// file: hdl/prs_pkg.sv
// Purpose: Shared constants and types of the rail strobe sequencer.
// Assumes: A 20 MHz system clock and byte-wide registers.
// Notes: Every offset, reset value and timing count lives here.
package prs_pkg;
    // Register offsets.
    localparam logic [7:0] ADDR_GAP_LO = 8'h20;
    localparam logic [7:0] ADDR_GAP_HI = 8'h21;
    localparam logic [7:0] ADDR_ASG_MAIN = 8'h23;
    localparam logic [7:0] ADDR_ASG_BACKUP = 8'h24;
    localparam logic [7:0] ADDR_ASG_SW_LDO = 8'h25;
    localparam logic [7:0] ADDR_STATUS = 8'h30;
    // Reset values.
    localparam logic [7:0] RST_GAP_LO = 8'h00;
    localparam logic [7:0] RST_GAP_HI = 8'h00;
    localparam logic [7:0] RST_ASG_MAIN = 8'h75;
    localparam logic [7:0] RST_ASG_BACKUP = 8'h12;
    localparam logic [7:0] RST_ASG_SW_LDO = 8'h63;
    // Writable bits; the rest read as zero.
    localparam logic [7:0] MASK_BACKUP = 8'h33;
    localparam logic [7:0] MASK_GAP_HI = 8'h81;
    // Field positions.
    localparam int FACTOR_BIT = 7;
    localparam int GAP9_BIT = 0;
    localparam int STAT_BUSY_BIT = 7;
    localparam int STAT_DOWN_BIT = 6;
    // Rail indices.
    localparam int NUM_RAILS = 6;
    localparam int RAIL_BUCKBOOST = 0;
    localparam int RAIL_BUCK3 = 1;
    localparam int RAIL_BACKUP_A = 2;
    localparam int RAIL_BACKUP_B = 3;
    localparam int RAIL_SWITCH_A = 4;
    localparam int RAIL_LINREG = 5;
    // Strobe numbers and field code limits.
    localparam logic [3:0] STROBE_NONE = 4'h0;
    localparam logic [3:0] STROBE_FIRST = 4'h1;
    localparam logic [3:0] STROBE_FIRST_SEALED = 4'h3;
    localparam logic [3:0] STROBE_LAST = 4'hA;
    localparam logic [1:0] CODE2_MIN = 2'h1;
    localparam logic [1:0] CODE2_MAX = 2'h2;
    // Timing: times in microseconds, counts derived and rounded up.
    localparam int CLK_KHZ = 20000;
    localparam int GAP_SHORT_US = 2000;
    localparam int GAP_LONG_US = 5000;
    localparam int DOWN_FACTOR = 10;
    localparam int GAP_SHORT_CYC = (CLK_KHZ * GAP_SHORT_US + 999) / 1000;
    localparam int GAP_LONG_CYC = (CLK_KHZ * GAP_LONG_US + 999) / 1000;
    localparam int CNT_W = 20;
    // Sequencer states.
    typedef enum logic [2:0] {IDLE, UP_STEP, UP_GAP, DN_STEP, DN_GAP} prs_state_type;
endpackage : prs_pkg

// file: hdl/prs_timer_if.sv
// Purpose: Carries a gap request to the delay timer and its end back.
// Assumes: One clock domain shared by both ends.
// Notes: Start is a one-cycle pulse; done is a one-cycle pulse.
interface prs_timer_if;
    logic start; // Pulse that loads a new gap.
    logic long_sel; // High for the long gap.
    logic times_ten; // High to stretch the gap tenfold.
    logic done; // Pulse when the gap has run out.
    modport seq (output start, output long_sel, output times_ten, input done);
    modport tmr (input start, input long_sel, input times_ten, output done);
endinterface : prs_timer_if

// file: hdl/prs_gap_timer.sv
// Purpose: Counts one inter-strobe gap of short or long length.
// Assumes: Start only arrives while the timer is idle.
// Notes: Done pulses in the cycle the count reaches zero.
module prs_gap_timer
    import prs_pkg::*;
#(
    parameter int SHORT_CYC = prs_pkg::GAP_SHORT_CYC, // Short gap in cycles.
    parameter int LONG_CYC = prs_pkg::GAP_LONG_CYC // Long gap in cycles.
) (
    input wire logic clk_i, // System clock.
    input wire logic resetn_i, // Synchronous reset, active low.
    prs_timer_if.tmr tmr // Gap request and end.
);
    // Refuse lengths that the counter cannot hold.
    if (SHORT_CYC < 1 || LONG_CYC < 1 || LONG_CYC * DOWN_FACTOR > 2 ** CNT_W) begin : g_chk
        $error("Gap length does not fit the counter.");
    end

    localparam logic [CNT_W-1:0] LOAD_S1 = CNT_W'(SHORT_CYC - 1);
    localparam logic [CNT_W-1:0] LOAD_L1 = CNT_W'(LONG_CYC - 1);
    localparam logic [CNT_W-1:0] LOAD_S10 = CNT_W'(SHORT_CYC * DOWN_FACTOR - 1);
    localparam logic [CNT_W-1:0] LOAD_L10 = CNT_W'(LONG_CYC * DOWN_FACTOR - 1);

    typedef struct packed {
        logic busy; // A gap is running.
        logic [CNT_W-1:0] cnt; // Cycles left minus one.
    } prs_tmr_type;

    prs_tmr_type cur; // Registered state.
    prs_tmr_type nxt; // Next state.

    // Load on start, count down, finish at zero.
    always_comb begin
        nxt = cur;
        tmr.done = cur.busy && cur.cnt == '0;
        if (tmr.start) begin
            nxt.busy = 1'b1;
            if (tmr.times_ten) begin
                nxt.cnt = tmr.long_sel ? LOAD_L10 : LOAD_S10;
            end else begin
                nxt.cnt = tmr.long_sel ? LOAD_L1 : LOAD_S1;
            end
        end else if (tmr.done) begin
            nxt.busy = 1'b0;
        end else if (cur.busy) begin
            nxt.cnt = cur.cnt - 1'b1;
        end
    end

    // Register the state.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    gap_load_a: assert property (tmr.start && !tmr.times_ten |=>
        cur.cnt == ($past(tmr.long_sel) ? LOAD_L1 : LOAD_S1))
        else $error("Gap loaded with the wrong length.");
    stretch_load_a: assert property (tmr.start && tmr.times_ten |=>
        cur.cnt == ($past(tmr.long_sel) ? LOAD_L10 : LOAD_S10))
        else $error("Stretched gap loaded with the wrong length.");
endmodule : prs_gap_timer

// file: hdl/prs_sequencer.sv
// Purpose: Assigns rails to numbered strobes and runs power sequences.
// Assumes: Request and seal pins are asynchronous; direct enables are not.
// Notes: One sequence runs at a time; requests during one are dropped.
//
// Design decision made here: the plain strobed port.
module prs_sequencer
    import prs_pkg::*;
#(
    parameter int GAP_SHORT_CYC = prs_pkg::GAP_SHORT_CYC, // Short gap in cycles.
    parameter int GAP_LONG_CYC = prs_pkg::GAP_LONG_CYC // Long gap in cycles.
) (
    input wire logic SYS_CLK_I, // System clock, 20 MHz.
    input wire logic RESETN_I, // Synchronous reset, active low.
    input wire logic [7:0] ADDR_I, // Register address.
    input wire logic [7:0] WR_DATA_I, // Write data.
    input wire logic WR_STB_I, // Write strobe.
    input wire logic RD_STB_I, // Read strobe.
    output logic [7:0] RD_DATA_O, // Read data, one cycle later.
    input wire logic FRESH_SEAL_I, // Seal flag, high once broken.
    input wire logic PWR_UP_REQ_I, // Rising edge starts power-up.
    input wire logic PWR_DN_REQ_I, // Rising edge starts power-down.
    input wire logic [prs_pkg::NUM_RAILS-1:0] DIRECT_EN_I, // Direct enables.
    output logic [prs_pkg::NUM_RAILS-1:0] RAIL_EN_O, // Rail enables.
    output logic [3:0] STROBE_O, // Current strobe number.
    output logic SEQ_BUSY_O // A sequence is running.
);
    // All state of the block.
    typedef struct packed {
        logic [7:0] gap_lo; // Gap selects one to eight.
        logic [7:0] gap_hi; // Factor bit and gap select nine.
        logic [7:0] asg_main; // Buck-boost and buck three fields.
        logic [7:0] asg_backup; // Backup converter fields.
        logic [7:0] asg_sw_ldo; // Load switch and linear regulator fields.
        logic [7:0] rd_data; // Read data for one cycle.
        logic [1:0] seal_sync; // Seal synchroniser, bit 1 is safe.
        logic [1:0] up_sync; // Power-up request synchroniser.
        logic [1:0] dn_sync; // Power-down request synchroniser.
        logic up_prev; // Last safe power-up level.
        logic dn_prev; // Last safe power-down level.
        prs_state_type state; // Sequencer state.
        logic [3:0] strb; // Current strobe number.
        logic [NUM_RAILS-1:0] rail_on; // Sequenced rail levels.
        logic [NUM_RAILS-1:0] rail_en; // Rail enables as driven.
    } prs_regs_type;

    prs_regs_type cur; // Registered state.
    prs_regs_type next_regs; // Next state.
    prs_timer_if tif (); // Link to the gap timer.

    // Maps a four-bit field code to its strobe, or none.
    function automatic logic [3:0] decode4(input logic [3:0] code);
        if (code >= STROBE_FIRST_SEALED && code <= STROBE_LAST) begin
            return code;
        end
        return STROBE_NONE;
    endfunction : decode4

    // Maps a two-bit backup field code to its strobe, or none.
    function automatic logic [3:0] decode2(input logic [1:0] code);
        if (code >= CODE2_MIN && code <= CODE2_MAX) begin
            return {2'h0, code};
        end
        return STROBE_NONE;
    endfunction : decode2

    // Strobe assigned to one rail by the current fields.
    function automatic logic [3:0] rail_strobe(input prs_regs_type r, input int idx);
        case (idx)
            RAIL_BUCKBOOST: return decode4(r.asg_main[7:4]);
            RAIL_BUCK3: return decode4(r.asg_main[3:0]);
            RAIL_BACKUP_A: return decode2(r.asg_backup[1:0]);
            RAIL_BACKUP_B: return decode2(r.asg_backup[5:4]);
            RAIL_SWITCH_A: return decode4(r.asg_sw_ldo[7:4]);
            RAIL_LINREG: return decode4(r.asg_sw_ldo[3:0]);
            default: return STROBE_NONE;
        endcase
    endfunction : rail_strobe

    // Gap select for the gap after strobe k (k from one to nine).
    function automatic logic gap_bit(input prs_regs_type r, input logic [3:0] k);
        logic [8:0] gaps;
        gaps = {r.gap_hi[GAP9_BIT], r.gap_lo};
        return gaps[4'(k - 4'h1)];
    endfunction : gap_bit

    logic seal; // Seal broken, synchronised.
    logic [3:0] first_strb; // Lowest strobe that may fire.
    logic gap_start; // Start a gap.
    logic gap_long; // The gap is the long one.
    logic gap_x10; // The gap is stretched.

    // Next-state logic: bus, synchronisers, sequencer and rail outputs.
    always_comb begin
        next_regs = cur;
        gap_start = 1'b0;
        gap_long = 1'b0;
        gap_x10 = 1'b0;
        seal = cur.seal_sync[1];
        // Strobes one and two only run while the seal is whole.
        first_strb = seal ? STROBE_FIRST_SEALED : STROBE_FIRST;

        // Only the second flop of each pair is looked at.
        next_regs.seal_sync = {cur.seal_sync[0], FRESH_SEAL_I};
        next_regs.up_sync = {cur.up_sync[0], PWR_UP_REQ_I};
        next_regs.dn_sync = {cur.dn_sync[0], PWR_DN_REQ_I};
        next_regs.up_prev = cur.up_sync[1];
        next_regs.dn_prev = cur.dn_sync[1];

        // Read data stands for exactly one cycle; unmapped reads give zero.
        next_regs.rd_data = 8'h00;
        if (RD_STB_I) begin
            case (ADDR_I)
                ADDR_GAP_LO: next_regs.rd_data = cur.gap_lo;
                ADDR_GAP_HI: next_regs.rd_data = cur.gap_hi;
                ADDR_ASG_MAIN: next_regs.rd_data = cur.asg_main;
                ADDR_ASG_BACKUP: next_regs.rd_data = cur.asg_backup;
                ADDR_ASG_SW_LDO: next_regs.rd_data = cur.asg_sw_ldo;
                ADDR_STATUS: begin
                    next_regs.rd_data[STAT_BUSY_BIT] = cur.state != IDLE;
                    next_regs.rd_data[STAT_DOWN_BIT] = cur.state == DN_STEP
                        || cur.state == DN_GAP;
                    next_regs.rd_data[3:0] = cur.strb;
                end
                default: next_regs.rd_data = 8'h00;
            endcase
        end

        // Writes take effect at once; a running sequence sees new fields.
        if (WR_STB_I) begin
            case (ADDR_I)
                ADDR_GAP_LO: next_regs.gap_lo = WR_DATA_I;
                ADDR_GAP_HI: next_regs.gap_hi = WR_DATA_I & MASK_GAP_HI;
                ADDR_ASG_MAIN: next_regs.asg_main = WR_DATA_I;
                // Reserved bits are dropped so they read as zero.
                ADDR_ASG_BACKUP: next_regs.asg_backup = WR_DATA_I & MASK_BACKUP;
                ADDR_ASG_SW_LDO: next_regs.asg_sw_ldo = WR_DATA_I;
                default: next_regs.asg_main = cur.asg_main;
            endcase
        end

        // The sequencer proper.
        case (cur.state)
            IDLE: begin
                // Power-up wins when both requests rise together.
                if (cur.up_sync[1] && !cur.up_prev) begin
                    next_regs.state = UP_STEP;
                    next_regs.strb = first_strb;
                end else if (cur.dn_sync[1] && !cur.dn_prev) begin
                    next_regs.state = DN_STEP;
                    next_regs.strb = STROBE_LAST;
                end
            end
            UP_STEP: begin
                // Switch on every rail assigned to this strobe.
                for (int i = 0; i < NUM_RAILS; i++) begin
                    if (rail_strobe(cur, i) == cur.strb) begin
                        next_regs.rail_on[i] = 1'b1;
                    end
                end
                if (cur.strb == STROBE_LAST) begin
                    next_regs.state = IDLE;
                end else begin
                    gap_start = 1'b1;
                    gap_long = gap_bit(cur, cur.strb);
                    next_regs.state = UP_GAP;
                end
            end
            UP_GAP: begin
                if (tif.done) begin
                    next_regs.strb = cur.strb + 4'h1;
                    next_regs.state = UP_STEP;
                end
            end
            DN_STEP: begin
                // Switch off every rail assigned to this strobe.
                for (int i = 0; i < NUM_RAILS; i++) begin
                    // Backup rails stay on for good once the seal is broken.
                    if (rail_strobe(cur, i) == cur.strb && !(seal
                        && (i == RAIL_BACKUP_A || i == RAIL_BACKUP_B))) begin
                        next_regs.rail_on[i] = 1'b0;
                    end
                end
                if (cur.strb <= first_strb) begin
                    next_regs.state = IDLE;
                end else begin
                    gap_start = 1'b1;
                    gap_long = gap_bit(cur, cur.strb - 4'h1);
                    gap_x10 = cur.gap_hi[FACTOR_BIT];
                    next_regs.state = DN_GAP;
                end
            end
            DN_GAP: begin
                if (tif.done) begin
                    next_regs.strb = cur.strb - 4'h1;
                    next_regs.state = DN_STEP;
                end
            end
            default: next_regs.state = IDLE;
        endcase

        // Unsequenced rails follow the direct enable.
        for (int i = 0; i < NUM_RAILS; i++) begin
            if (rail_strobe(cur, i) == STROBE_NONE) begin
                next_regs.rail_en[i] = DIRECT_EN_I[i];
            end else begin
                next_regs.rail_en[i] = next_regs.rail_on[i];
            end
        end
    end

    assign tif.start = gap_start;
    assign tif.long_sel = gap_long;
    assign tif.times_ten = gap_x10;

    // Register all state; fields load their stored defaults.
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            cur <= '0;
            cur.gap_lo <= RST_GAP_LO;
            cur.gap_hi <= RST_GAP_HI;
            cur.asg_main <= RST_ASG_MAIN;
            cur.asg_backup <= RST_ASG_BACKUP;
            cur.asg_sw_ldo <= RST_ASG_SW_LDO;
            cur.state <= IDLE;
        end else begin
            cur <= next_regs;
        end
    end

    // The gap timer times the pause after each strobe but the last of a sequence.
    prs_gap_timer #(
        .SHORT_CYC(GAP_SHORT_CYC),
        .LONG_CYC(GAP_LONG_CYC)
    ) u_gap_timer (
        .clk_i(SYS_CLK_I),
        .resetn_i(RESETN_I),
        .tmr(tif.tmr)
    );

    // Outputs come from flops; the busy flag is decoded from the state flops.
    assign RD_DATA_O = cur.rd_data;
    assign RAIL_EN_O = cur.rail_en;
    assign STROBE_O = cur.strb;
    assign SEQ_BUSY_O = cur.state != IDLE;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);

    // A strobe step followed by the start of its gap.
    sequence up_step_gap;
        cur.state == UP_STEP && cur.strb != STROBE_LAST ##1 cur.state == UP_GAP;
    endsequence

    // One strobe step on the way up.
    sequence up_strobe;
        cur.state == UP_STEP;
    endsequence

    main_code_a: assert property (up_strobe and ##0
        decode4(cur.asg_main[7:4]) == cur.strb |=> cur.rail_en[RAIL_BUCKBOOST])
        else $error("Buck-boost missed its strobe.");
    high_code_a: assert property (cur.asg_main[3:0] > STROBE_LAST |=>
        cur.rail_en[RAIL_BUCK3] == $past(DIRECT_EN_I[RAIL_BUCK3]))
        else $error("Rail with high code not left to direct control.");
    low_code_a: assert property (cur.asg_sw_ldo[3:0] < STROBE_FIRST_SEALED |=>
        cur.rail_en[RAIL_LINREG] == $past(DIRECT_EN_I[RAIL_LINREG]))
        else $error("Rail with low code not left to direct control.");
    reset_vals_a: assert property ($rose(RESETN_I) |-> cur.asg_main == RST_ASG_MAIN
        && cur.asg_backup == RST_ASG_BACKUP && cur.asg_sw_ldo == RST_ASG_SW_LDO)
        else $error("Assignment fields not at their defaults.");
    backup_rsvd_a: assert property ((cur.asg_backup & ~MASK_BACKUP) == 8'h00)
        else $error("Reserved backup bits set.");
    backup_code_a: assert property (up_strobe and ##0
        decode2(cur.asg_backup[5:4]) == cur.strb |=> cur.rail_en[RAIL_BACKUP_B])
        else $error("Backup rail missed its strobe.");
    backup_free_a: assert property (cur.asg_backup[1:0] == 2'h3 |=>
        cur.rail_en[RAIL_BACKUP_A] == $past(DIRECT_EN_I[RAIL_BACKUP_A]))
        else $error("Backup rail with code 3h still sequenced.");
    sealed_skip_a: assert property (cur.seal_sync[1] && cur.state == IDLE
        ##1 cur.state == UP_STEP |-> cur.strb == STROBE_FIRST_SEALED)
        else $error("Low strobe issued with the seal broken.");
    backup_keep_a: assert property (cur.seal_sync[1] && cur.state == DN_STEP
        && cur.rail_on[RAIL_BACKUP_A] |=> cur.rail_on[RAIL_BACKUP_A])
        else $error("Backup rail switched off after the seal broke.");
    gap_start_a: assert property (up_step_gap |-> $past(tif.long_sel)
        == gap_bit(cur, cur.strb) && !$past(tif.times_ten))
        else $error("Power-up gap has the wrong length or stretch.");
    down_factor_a: assert property (cur.state == DN_STEP && tif.start |->
        tif.times_ten == cur.gap_hi[FACTOR_BIT])
        else $error("Power-down stretch does not follow the factor bit.");
    up_order_a: assert property (cur.state == UP_GAP && tif.done |=>
        cur.state == UP_STEP && cur.strb == $past(cur.strb) + 4'h1)
        else $error("Power-up strobes out of order.");
    down_order_a: assert property (cur.state == DN_GAP && tif.done |=>
        cur.state == DN_STEP && cur.strb == $past(cur.strb) - 4'h1)
        else $error("Power-down strobes out of order.");
    direct_follow_a: assert property (rail_strobe(cur, RAIL_SWITCH_A) == STROBE_NONE
        |=> cur.rail_en[RAIL_SWITCH_A] == $past(DIRECT_EN_I[RAIL_SWITCH_A]))
        else $error("Unsequenced switch ignores its direct enable.");
endmodule : prs_sequencer

// file: bench/prs_sequencer_tb.sv
// Purpose: Self-checking bench for the rail strobe sequencer.
// Assumes: Gap counts of 4 and 7 cycles stand in for the long real gaps.
// Notes: Expectations come from bench functions, never from design outputs.
module prs_sequencer_tb import prs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SHORT = 4; // Short gap in cycles.
    localparam int LONG = 7; // Long gap in cycles.
    logic clk = 1'b0, resetn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0; // Bus and reset.
    logic seal = 1'b0, up_req = 1'b0, dn_req = 1'b0, last_busy, busy; // Pins.
    logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, rd_v, r23, r24, r25, g20, g21; // Bus.
    logic [5:0] direct_en = 6'h00, rail_en, rails_m; // Rail enables and their model.
    logic [3:0] strobe, last_stb; // Strobe number seen.
    logic [31:0] lfsr = 32'h75DE; // Random source.
    int num_errors = 0, num_checks = 0, exp_stb, dir, first, n_stb, cyc, t_last, gap;

    prs_sequencer #(.GAP_SHORT_CYC(SHORT), .GAP_LONG_CYC(LONG)) dut_u (.SYS_CLK_I(clk),
        .RESETN_I(resetn), .ADDR_I(addr), .WR_DATA_I(wr_data), .WR_STB_I(wr_stb),
        .RD_STB_I(rd_stb), .RD_DATA_O(rd_data), .FRESH_SEAL_I(seal), .PWR_UP_REQ_I(up_req),
        .PWR_DN_REQ_I(dn_req), .DIRECT_EN_I(direct_en), .RAIL_EN_O(rail_en),
        .STROBE_O(strobe), .SEQ_BUSY_O(busy));

    // The clock toggles every 25 ns, half of its 50 ns period.
    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    // Galois shift register, stepped once per draw so runs repeat exactly.
    function automatic void rnd();
        lfsr = (lfsr >> 1) ^ (lfsr[0] ? 32'h80200003 : 32'h00000000);
    endfunction : rnd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wr_data <= d; wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe, so sample it there.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a; rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        chk(rd_data, exp, "read data");
    endtask : rd

    // Strobe of rail r, or zero when the code leaves it unsequenced.
    function automatic int stb_of(input int r);
        logic [3:0] c;
        case (r)
            0: c = r23[7:4];
            1: c = r23[3:0];
            2: c = {2'b00, r24[1:0]};
            3: c = {2'b00, r24[5:4]};
            4: c = r25[7:4];
            default: c = r25[3:0];
        endcase
        if (r == 2 || r == 3) return (c == 4'h1 || c == 4'h2) ? int'(c) : 0;
        return (c >= 4'h3 && c <= 4'hA) ? int'(c) : 0;
    endfunction : stb_of

    // Sequenced levels after mode 0 power-down or 1 power-up; skipped strobes keep the level.
    // Unsequenced rails keep their hidden level, which shows again once they are assigned.
    function automatic logic [5:0] model(input int mode, input logic [5:0] prev);
        logic [5:0] res;
        res = prev;
        for (int r = 0; r < 6; r++) begin
            if (stb_of(r) != 0 && !(stb_of(r) < 3 && seal)) res[r] = (mode == 1);
        end
        return res;
    endfunction : model

    // Expected enables: unsequenced rails show the direct enable, the rest their level.
    function automatic logic [5:0] exp_en(input logic [5:0] lvl);
        logic [5:0] res;
        for (int r = 0; r < 6; r++) begin
            res[r] = (stb_of(r) == 0) ? direct_en[r] : lvl[r];
        end
        return res;
    endfunction : exp_en

    function automatic logic gsel(input int k);
        return (k <= 8) ? g20[k-1] : g21[0];
    endfunction : gsel

    // Each new step must carry the next strobe and keep the gap its select bit asks for.
    always @(negedge clk) begin
        cyc++;
        if (busy === 1'b1 && (last_busy !== 1'b1 || strobe !== last_stb)) begin
            chk(strobe, exp_stb, "strobe order");
            if (n_stb > 0) begin
                gap = (gsel(dir > 0 ? exp_stb - 1 : exp_stb) ? LONG : SHORT);
                gap = gap * ((dir < 0 && g21[7]) ? DOWN_FACTOR : 1);
                // Step to step spans the gap count plus the step cycle itself.
                chk(cyc - t_last - gap, 1, "gap length");
            end
            n_stb++;
            t_last = cyc;
            exp_stb += dir;
        end
        last_busy = busy;
        last_stb = strobe;
    end

    task automatic run_seq(input logic up);
        first = seal ? 3 : 1;
        dir = up ? 1 : -1;
        exp_stb = up ? first : 10;
        n_stb = 0;
        @(posedge clk);
        if (up) up_req <= 1'b1;
        else dn_req <= 1'b1;
        for (int i = 0; i < 50 && busy !== 1'b1; i++) @(negedge clk);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
        @(posedge clk);
        up_req <= 1'b0;
        dn_req <= 1'b0;
        repeat (4) @(negedge clk);
        chk(n_stb, 11 - first, "strobe count");
        rails_m = model(up ? 1 : 0, rails_m);
        chk(rail_en, exp_en(rails_m), "rails after sequence");
    endtask : run_seq

    // Watchdog sized well above the expected worst case of about twelve thousand cycles.
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        // An unmapped write must leave the status and assignment registers at their defaults.
        wr(8'h2F, 8'hFF);
        rd(ADDR_STATUS, 8'h00);
        rd(8'h23, 8'h75);
        rd(8'h24, 8'h12);
        rd(8'h25, 8'h63);
        rd(8'h2F, 8'h00);
        rails_m = 6'h00;
        for (int it = 0; it < 16; it++) begin
            rnd();
            r23 = {4'(it), 4'(it + 3)};
            r25 = {4'(it + 6), 4'(it + 9)};
            r24 = lfsr[7:0];
            g20 = lfsr[15:8];
            g21 = lfsr[23:16];
            @(posedge clk);
            seal <= lfsr[24];
            direct_en <= lfsr[30:25];
            wr(8'h23, r23);
            wr(8'h24, r24);
            wr(8'h25, r25);
            wr(ADDR_GAP_LO, g20);
            wr(ADDR_GAP_HI, g21);
            r24 = r24 & MASK_BACKUP;
            g21 = g21 & MASK_GAP_HI;
            rd(8'h24, r24);
            rd(8'h23, r23);
            rd(8'h25, r25);
            rd(ADDR_GAP_HI, g21);
            chk(rail_en, exp_en(rails_m), "direct follow");
            run_seq(1'b1);
            run_seq(1'b0);
        end
        conclude();
    end
endmodule : prs_sequencer_tb
